/* File: verilog/link_buf_defs.svh */
`ifndef LINK_BUF_DEFS_SVH
`define LINK_BUF_DEFS_SVH

// Word address space
`define MEM_WORDS   3584
`define MEM_TOP     12'hE00
`define SPC_FIRST   12'h100
`define SPC_LAST    12'h11F

// Special area word addresses
`define A_END_CODE  12'h100
`define A_ERR_STATE 12'h101
`define A_ERR_CLR   12'h102
`define A_UNIT      12'h103
`define A_SND_START 12'h104
`define A_SND_SIZE  12'h105
`define A_RCV_START 12'h106
`define A_RCV_SIZE  12'h107
`define A_FIX_LEN   12'h108
`define A_OD_START  12'h109
`define A_OD_SIZE   12'h10A
`define A_OD_ERR    12'h10C
`define A_FLUSH     12'h10D
`define A_RSVD_A    12'h10E
`define A_BIDI      12'h10F
`define A_TMO       12'h110
`define A_SIMULT    12'h111
`define A_CKSUM     12'h112
`define A_SND_ERR   12'h113
`define A_RCV_ERR   12'h114
`define A_MODE      12'h118
`define A_TARGET    12'h119
`define A_FLOW      12'h11A
`define A_CODES_A   12'h11B
`define A_CODES_B   12'h11C
`define A_RSVD_B    12'h11D

// Reset values and the bidirectional enable value
`define D_END_CODE  16'h0D0A
`define D_SIZE      16'h0080
`define D_FIX_LEN   16'h007F
`define D_CODES_A   16'h1311
`define D_CODES_B   16'h1412
`define BIDI_ON     16'h0001

// Modes
`define MODE_UNFRAMED 4'h4
`define MODE_P1       4'h5
`define MODE_P4       4'h8

// Timing
`define CLK_NS      50
`define INIT_NS     2000000000
`define INIT_CYC    ((`INIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: verilog/link_buf_pkg.sv */
package link_buf_pkg;

  typedef logic [15:0] word_t;
  typedef logic [11:0] addr_t;
  typedef logic [3:0]  mode_t;

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_DONE} init_state_e;

  typedef struct packed {
    logic [3:0] err;
    logic       ack;
    logic       nak;
    logic       idle;
    logic       md;
    logic       com;
    logic       tx;
  } ind_s;

  typedef struct packed {
    word_t       end_code;
    word_t       err_clr;
    word_t       unit;
    word_t       snd_start;
    word_t       snd_size;
    word_t       rcv_start;
    word_t       rcv_size;
    word_t       fix_len;
    word_t       od_start;
    word_t       od_size;
    word_t       flush;
    word_t       bidi;
    word_t       tmo;
    word_t       simult;
    word_t       cksum;
    word_t       target;
    word_t       flow;
    word_t       codes_a;
    word_t       codes_b;
    mode_t       mode;
    word_t       cpu_rdata;
    word_t       link_rdata;
    logic        cpu_ack;
    logic        link_ack;
    logic        ready;
    logic        done;
    logic        chg;
    logic        req_q;
    logic        clr_stb;
    logic [3:0]  clr_mask;
    logic        flush_stb;
    logic        ind_init;
    logic        bidir;
    logic        word_units;
    logic        cksum_en;
    logic        simult_ok;
    logic        flow_on;
    logic        rx_accept;
    logic [31:0] cnt;
    init_state_e st;
  } map_s;

endpackage : link_buf_pkg

/* File: verilog/link_indicators.sv */
`timescale 1ns/1ns
`include "link_buf_defs.svh"

module link_indicators (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // Control
  input  wire logic               init_pulse,
  input  wire link_buf_pkg::mode_t mode,
  input  wire logic               link_type_switch,
  input  wire logic               station_role_switch,
  input  wire logic               clr_stb,
  input  wire logic [3:0]         clr_mask,
  // Events
  input  wire logic [3:0]         err_evt,
  input  wire logic               ack_sent,
  input  wire logic               nak_sent,
  input  wire logic               enq_wait,
  input  wire logic               enq_rcvd,
  input  wire logic               tx_active,
  // Indicators
  output logic [3:0]              err_state,
  output logic                    ack_ind,
  output logic                    nak_ind,
  output logic                    idle_sequence_ind,
  output logic                    multidrop_ind,
  output logic                    link_ind,
  output logic                    transmit_activity_ind
);
  import link_buf_pkg::*;

  ind_s r, n;

  always_comb
  begin
    n = r;
    if (clr_stb)
      n.err = r.err & ~clr_mask;
    if (init_pulse)
    begin
      n.err  = 4'h0;
      n.ack  = 1'b0;
      n.nak  = 1'b0;
      n.idle = (mode >= `MODE_P1) && (mode <= `MODE_P4);
    end
    else if (enq_rcvd)
      n.idle = 1'b0;
    else if (enq_wait)
      n.idle = 1'b1;
    n.err = n.err | err_evt;
    if (ack_sent)
    begin
      n.ack = 1'b1;
      n.nak = 1'b0;
    end
    else if (nak_sent)
    begin
      n.ack = 1'b0;
      n.nak = 1'b1;
    end
    n.md  = !link_type_switch;
    n.com = !(!link_type_switch && station_role_switch);
    n.tx  = tx_active;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end

  assign err_state             = r.err;
  assign ack_ind               = r.ack;
  assign nak_ind               = r.nak;
  assign idle_sequence_ind     = r.idle;
  assign multidrop_ind         = r.md;
  assign link_ind              = r.com;
  assign transmit_activity_ind = r.tx;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_latch;
    r.err[3] && !clr_stb && !init_pulse |=> r.err[3];
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched error indicator dropped");

  wire serial_err_on = r.err[3];

  property p_sio;
    err_evt[3] |=> serial_err_on;
  endproperty
  a_sio: assert property (p_sio)
    else $error("serial error indicator not lit");

  property p_ack;
    ack_sent |=> ack_ind && !nak_ind;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge indicators wrong");

  property p_idle;
    init_pulse && mode == `MODE_UNFRAMED && !enq_wait |=> !idle_sequence_ind;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle indicator on in unframed mode");

  property p_link;
    link_type_switch ##1 link_type_switch |-> !multidrop_ind && link_ind;
  endproperty
  a_link: assert property (p_link)
    else $error("link indicators wrong");

endmodule : link_indicators

/* File: verilog/serial_link_buffer_memory_map.sv */
`timescale 1ns/1ns
`include "link_buf_defs.svh"

module serial_link_buffer_memory_map #(
  parameter int INIT_CYCLES = `INIT_CYC
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Controller word access
  input  wire logic                cpu_req,
  input  wire logic                cpu_we,
  input  wire link_buf_pkg::addr_t cpu_addr,
  input  wire link_buf_pkg::word_t cpu_wdata,
  output link_buf_pkg::word_t      cpu_rdata,
  output logic                     cpu_ack,
  // Serial buffer commands
  input  wire logic                link_req,
  input  wire logic                buffer_write_command,
  input  wire link_buf_pkg::addr_t link_addr,
  input  wire link_buf_pkg::word_t link_wdata,
  output link_buf_pkg::word_t      link_rdata,
  output logic                     link_ack,
  // Mode handshake and straps
  input  wire logic                mode_change_req,
  output logic                     mode_change_done_in,
  output logic                     device_ready,
  input  wire link_buf_pkg::mode_t mode_switch,
  input  wire logic                link_type_switch,
  input  wire logic                station_role_switch,
  // Engine status
  input  wire link_buf_pkg::word_t ondemand_err_in,
  input  wire link_buf_pkg::word_t send_err_in,
  input  wire link_buf_pkg::word_t receive_err_in,
  input  wire logic                rx_valid,
  input  wire logic                rx_full,
  input  wire logic                overrun_evt,
  input  wire logic                framing_evt,
  input  wire logic                parity_evt,
  input  wire logic                sum_evt,
  input  wire logic                protocol_evt,
  input  wire logic                cpu_comm_evt,
  input  wire logic                ack_sent,
  input  wire logic                nak_sent,
  input  wire logic                enq_wait,
  input  wire logic                enq_rcvd,
  input  wire logic                tx_active,
  // Configuration to engines
  output logic                     bidir_mode,
  output logic                     word_units,
  output logic                     checksum_en,
  output logic                     simult_data_valid,
  output logic                     flow_control_on,
  output logic                     rx_accept,
  output logic                     rx_flush,
  // Indicators
  output logic                     cpu_comm_ind,
  output logic                     parity_error_ind,
  output logic                     protocol_error_ind,
  output logic                     serial_error_ind,
  output logic                     ack_ind,
  output logic                     nak_ind,
  output logic                     idle_sequence_ind,
  output logic                     multidrop_ind,
  output logic                     link_ind,
  output logic                     transmit_activity_ind
);
  import link_buf_pkg::*;

  map_s       r, n;
  word_t      mem [0:`MEM_WORDS-1];
  logic [3:0] err;
  logic [3:0] err_evt;
  logic       mem_we;
  addr_t      mem_a;
  word_t      mem_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and register access

  function automatic logic is_user(addr_t a);
    is_user = (a < `SPC_FIRST) || ((a > `SPC_LAST) && (a < `MEM_TOP));
  endfunction : is_user

  function automatic word_t rd_word(map_s s, addr_t a, word_t m,
                                    logic [3:0] e);
    rd_word = 16'h0000;
    if (is_user(a))
      rd_word = m;
    else
      case (a)
        `A_END_CODE:  rd_word = s.end_code;
        `A_ERR_STATE: rd_word = {12'h000, e};
        `A_ERR_CLR:   rd_word = s.err_clr;
        `A_UNIT:      rd_word = s.unit;
        `A_SND_START: rd_word = s.snd_start;
        `A_SND_SIZE:  rd_word = s.snd_size;
        `A_RCV_START: rd_word = s.rcv_start;
        `A_RCV_SIZE:  rd_word = s.rcv_size;
        `A_FIX_LEN:   rd_word = s.fix_len;
        `A_OD_START:  rd_word = s.od_start;
        `A_OD_SIZE:   rd_word = s.od_size;
        `A_OD_ERR:    rd_word = ondemand_err_in;
        `A_FLUSH:     rd_word = s.flush;
        `A_BIDI:      rd_word = s.bidi;
        `A_TMO:       rd_word = s.tmo;
        `A_SIMULT:    rd_word = s.simult;
        `A_CKSUM:     rd_word = s.cksum;
        `A_SND_ERR:   rd_word = send_err_in;
        `A_RCV_ERR:   rd_word = receive_err_in;
        `A_MODE:      rd_word = {12'h000, s.mode};
        `A_TARGET:    rd_word = s.target;
        `A_FLOW:      rd_word = s.flow;
        `A_CODES_A:   rd_word = s.codes_a;
        `A_CODES_B:   rd_word = s.codes_b;
        default:      rd_word = 16'h0000;
      endcase
  endfunction : rd_word

  // Read-only and reserved words drop writes
  function automatic map_s wr_word(map_s s, addr_t a, word_t d);
    wr_word = s;
    case (a)
      `A_END_CODE:  wr_word.end_code  = d;
      `A_ERR_CLR:   wr_word.err_clr   = d;
      `A_UNIT:      wr_word.unit      = d;
      `A_SND_START: wr_word.snd_start = d;
      `A_SND_SIZE:  wr_word.snd_size  = d;
      `A_RCV_START: wr_word.rcv_start = d;
      `A_RCV_SIZE:  wr_word.rcv_size  = d;
      `A_FIX_LEN:   wr_word.fix_len   = d;
      `A_OD_START:  wr_word.od_start  = d;
      `A_OD_SIZE:   wr_word.od_size   = d;
      `A_FLUSH:     wr_word.flush     = d;
      `A_BIDI:      wr_word.bidi      = d;
      `A_TMO:       wr_word.tmo       = d;
      `A_SIMULT:    wr_word.simult    = d;
      `A_CKSUM:     wr_word.cksum     = d;
      `A_TARGET:    wr_word.target    = d;
      `A_FLOW:      wr_word.flow      = d;
      `A_CODES_A:   wr_word.codes_a   = d;
      `A_CODES_B:   wr_word.codes_b   = d;
      default:      wr_word = s;
    endcase
  endfunction : wr_word

  ////////////////////////////////////////////////////////////////////////////
  // Shared word array, CPU ahead of link

  always_comb
  begin
    mem_a  = cpu_req ? cpu_addr : link_addr;
    mem_we = cpu_req ? cpu_we :
             (link_req && !r.link_ack && buffer_write_command);
    mem_we = mem_we && is_user(mem_a);
    mem_q  = is_user(mem_a) ? mem[mem_a] : 16'h0000;
  end

  always_ff @(posedge core_clk)
  begin
    if (mem_we)
      mem[mem_a] <= cpu_req ? cpu_wdata : link_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n           = r;
    n.cpu_ack   = 1'b0;
    n.link_ack  = 1'b0;
    n.clr_stb   = 1'b0;
    n.flush_stb = 1'b0;
    n.ind_init  = 1'b0;
    n.req_q     = mode_change_req;
    // Service requests left by the previous write
    if (r.err_clr != 16'h0000)
    begin
      n.clr_stb  = 1'b1;
      n.clr_mask = r.err_clr[3:0];
      n.err_clr  = 16'h0000;
    end
    if (r.flush != 16'h0000)
    begin
      n.flush_stb = 1'b1;
      n.flush     = 16'h0000;
    end
    if (cpu_req)
    begin
      n.cpu_ack   = 1'b1;
      n.cpu_rdata = rd_word(r, cpu_addr, mem_q, err);
      if (cpu_we)
        n = wr_word(n, cpu_addr, cpu_wdata);
    end
    // Held link request answered on every other cycle
    else if (link_req && !r.link_ack)
    begin
      n.link_ack   = 1'b1;
      n.link_rdata = rd_word(r, link_addr, mem_q, err);
      if (buffer_write_command)
        n = wr_word(n, link_addr, link_wdata);
    end
    case (r.st)
      ST_INIT:
      begin
        n.ready = 1'b0;
        if (r.cnt >= 32'(INIT_CYCLES - 1))
        begin
          n.cnt      = 32'h0000_0000;
          n.ready    = 1'b1;
          n.ind_init = 1'b1;
          n.done     = r.chg;
          n.st       = r.chg ? ST_DONE : ST_RUN;
          if (!r.chg)
            n.mode = mode_switch;
          else if (r.target != 16'h0000)
            n.mode = r.target[3:0];
        end
        else
          n.cnt = r.cnt + 32'h0000_0001;
      end
      ST_RUN:
      begin
        if (mode_change_req && !r.req_q)
        begin
          n.chg   = 1'b1;
          n.ready = 1'b0;
          n.st    = ST_INIT;
        end
      end
      ST_DONE:
      begin
        if (!mode_change_req)
        begin
          n.done = 1'b0;
          n.chg  = 1'b0;
          n.st   = ST_RUN;
        end
      end
      default:
        n.st = ST_INIT;
    endcase
    n.bidir      = (r.mode == `MODE_UNFRAMED) &&
                   (r.bidi == `BIDI_ON);
    n.word_units = (r.unit == 16'h0000);
    n.cksum_en   = (r.cksum == 16'h0000);
    n.simult_ok  = (r.simult == 16'h0000);
    n.flow_on    = (r.flow != 16'h0000);
    n.rx_accept  = rx_valid && !rx_full;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with defaults

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      r           <= '0;
      r.end_code  <= `D_END_CODE;
      r.snd_size  <= `D_SIZE;
      r.rcv_start <= `D_SIZE;
      r.rcv_size  <= `D_SIZE;
      r.fix_len   <= `D_FIX_LEN;
      r.codes_a   <= `D_CODES_A;
      r.codes_b   <= `D_CODES_B;
      r.st        <= ST_INIT;
    end
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators

  always_comb
  begin
    err_evt[0] = cpu_comm_evt;
    err_evt[1] = parity_evt || sum_evt;
    err_evt[2] = protocol_evt;
    err_evt[3] = overrun_evt || framing_evt ||
                 (rx_valid && rx_full);
  end

  link_indicators u_ind (
    .core_clk              (core_clk),
    .rstn                  (rstn),
    .init_pulse            (r.ind_init),
    .mode                  (r.mode),
    .link_type_switch      (link_type_switch),
    .station_role_switch   (station_role_switch),
    .clr_stb               (r.clr_stb),
    .clr_mask              (r.clr_mask),
    .err_evt               (err_evt),
    .ack_sent              (ack_sent),
    .nak_sent              (nak_sent),
    .enq_wait              (enq_wait),
    .enq_rcvd              (enq_rcvd),
    .tx_active             (tx_active),
    .err_state             (err),
    .ack_ind               (ack_ind),
    .nak_ind               (nak_ind),
    .idle_sequence_ind     (idle_sequence_ind),
    .multidrop_ind         (multidrop_ind),
    .link_ind              (link_ind),
    .transmit_activity_ind (transmit_activity_ind)
  );

  assign cpu_comm_ind        = err[0];
  assign parity_error_ind    = err[1];
  assign protocol_error_ind  = err[2];
  assign serial_error_ind    = err[3];
  assign cpu_rdata           = r.cpu_rdata;
  assign cpu_ack             = r.cpu_ack;
  assign link_rdata          = r.link_rdata;
  assign link_ack            = r.link_ack;
  assign mode_change_done_in = r.done;
  assign device_ready        = r.ready;
  assign bidir_mode          = r.bidir;
  assign word_units          = r.word_units;
  assign checksum_en         = r.cksum_en;
  assign simult_data_valid   = r.simult_ok;
  assign flow_control_on     = r.flow_on;
  assign rx_accept           = r.rx_accept;
  assign rx_flush            = r.flush_stb;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_done_cause;
    $rose(mode_change_done_in) |-> mode_change_req && device_ready;
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("change completion without request");

  property p_done_drop;
    mode_change_done_in && !mode_change_req |=> !mode_change_done_in;
  endproperty
  a_done_drop: assert property (p_done_drop)
    else $error("completion held after request dropped");

  property p_defaults;
    $rose(rstn) |-> r.codes_a == `D_CODES_A && r.codes_b == `D_CODES_B &&
                    r.end_code == `D_END_CODE && r.rcv_start == `D_SIZE;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("special area defaults not loaded");

  property p_rsvd;
    cpu_req && cpu_addr == `A_RSVD_A |=> cpu_ack && cpu_rdata == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word not zero");

  property p_link_serve;
    link_req && !cpu_req && !link_ack |=> link_ack ##1 !link_ack || link_req;
  endproperty
  a_link_serve: assert property (p_link_serve)
    else $error("link access not answered");

  property p_bidir;
    r.mode == `MODE_UNFRAMED && r.bidi == `BIDI_ON |=> bidir_mode;
  endproperty
  a_bidir: assert property (p_bidir)
    else $error("bidirectional mode not selected");

  property p_err_word;
    cpu_req && !cpu_we && cpu_addr == `A_ERR_STATE
      |=> cpu_rdata[3:0] == $past(err);
  endproperty
  a_err_word: assert property (p_err_word)
    else $error("error state word mismatch");

endmodule : serial_link_buffer_memory_map

/* File: test/link_host_model.sv */
`timescale 1ns/1ns
module link_host_model (
  // Clock
  input  wire logic                core_clk,
  // Buffer command port
  output logic                     link_req,
  output logic                     buffer_write_command,
  output link_buf_pkg::addr_t      link_addr,
  output link_buf_pkg::word_t      link_wdata,
  input  wire link_buf_pkg::word_t link_rdata,
  input  wire logic                link_ack
);
  import link_buf_pkg::*;
  initial
  begin
    link_req = 1'b0;
    buffer_write_command = 1'b0;
    link_addr = 12'h000;
    link_wdata = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////
  // Holds the command until ack or for at most 8 clocks, then scrambles the released lines
  task xfer(input logic w, input addr_t a, input word_t d, output word_t r);
    int i;
    @(negedge core_clk);
    link_req = 1'b1;
    buffer_write_command = w;
    link_addr = a;
    link_wdata = d;
    i = 0;
    r = 16'hXXXX;
    while (i < 8 && link_ack !== 1'b1)
    begin
      @(posedge core_clk);
      i++;
    end
    if (link_ack === 1'b1)
      r = link_rdata;
    link_req <= 1'b0;
    link_addr <= ~a;
    link_wdata <= ~d;
  endtask : xfer
endmodule : link_host_model

/* File: test/serial_link_buffer_memory_map_test.sv */
`timescale 1ns/1ns
module serial_link_buffer_memory_map_test;
  import link_buf_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cpu_req = 1'b0;
  logic        cpu_we = 1'b0;
  addr_t       cpu_addr = 12'h000;
  word_t       cpu_wdata = 16'h0000;
  word_t       cpu_rdata;
  logic        cpu_ack;
  logic        link_req;
  logic        link_wr;
  addr_t       link_addr;
  word_t       link_wdata;
  word_t       link_rdata;
  logic        link_ack;
  logic        mode_req = 1'b0;
  logic        lts = 1'b0;
  logic        srs = 1'b1;
  logic        done;
  logic        ready;
  logic [12:0] ev = 13'h0000;
  logic [6:0]  cfg;
  logic [9:0]  ind;
  word_t       rd;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [27:0] tab [18] = '{
    28'h100_0D0A,
    28'h101_0000, 28'h102_0000,
    28'h103_0000,
    28'h104_0000, 28'h105_0080, 28'h106_0080, 28'h107_0080,
    28'h111_0000,
    28'h112_0000,
    28'h118_0000, 28'h119_0000,
    28'h11A_0000,
    28'h11B_1311, 28'h11C_1412,
    28'h10C_5A5A, 28'h113_5A5A, 28'h114_5A5A};

  always #25 core_clk = ~core_clk;

  serial_link_buffer_memory_map #(.INIT_CYCLES(64))
  u_serial_link_buffer_memory_map (
    .core_clk(core_clk), .rstn(rstn), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .link_req(link_req), .buffer_write_command(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .link_ack(link_ack),
    .mode_change_req(mode_req), .mode_change_done_in(done),
    .device_ready(ready), .mode_switch(4'h4), .link_type_switch(lts),
    .station_role_switch(srs), .ondemand_err_in(16'h5A5A),
    .send_err_in(16'h5A5A), .receive_err_in(16'h5A5A),
    .overrun_evt(ev[0]), .framing_evt(ev[1]), .parity_evt(ev[2]),
    .sum_evt(ev[3]), .protocol_evt(ev[4]), .cpu_comm_evt(ev[5]),
    .ack_sent(ev[6]), .nak_sent(ev[7]), .enq_wait(ev[8]),
    .enq_rcvd(ev[9]), .tx_active(ev[10]), .rx_valid(ev[11]),
    .rx_full(ev[12]), .bidir_mode(cfg[0]), .word_units(cfg[1]),
    .checksum_en(cfg[2]), .simult_data_valid(cfg[3]),
    .flow_control_on(cfg[4]), .rx_accept(cfg[5]), .rx_flush(cfg[6]),
    .cpu_comm_ind(ind[0]), .parity_error_ind(ind[1]),
    .protocol_error_ind(ind[2]), .serial_error_ind(ind[3]),
    .ack_ind(ind[4]), .nak_ind(ind[5]), .idle_sequence_ind(ind[6]),
    .multidrop_ind(ind[7]), .link_ind(ind[8]),
    .transmit_activity_ind(ind[9]));

  link_host_model u_link_host_model (
    .core_clk(core_clk), .link_req(link_req),
    .buffer_write_command(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_rdata(link_rdata), .link_ack(link_ack));
  //////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task chk(input string n, input word_t s, input word_t e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task cpu(input logic w, input addr_t a, input word_t d);
    @(negedge core_clk);
    cpu_req = 1'b1;
    cpu_we = w;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge core_clk);
    cpu_req = 1'b0;
    cpu_addr = ~a;
    chk("cpu_ack", 16'(cpu_ack), 16'h0001);
    rd = cpu_rdata;
  endtask : cpu

  task rc(input addr_t a, input word_t e);
    cpu(1'b0, a, 16'h0000);
    chk("word", rd, e);
  endtask : rc

  task pulse(input int b);
    @(negedge core_clk);
    ev[b] = 1'b1;
    @(negedge core_clk);
    ev[b] = 1'b0;
    @(negedge core_clk);
  endtask : pulse

  task automatic wait_for(ref logic s, input logic v);
    int i;
    for (i = 0; i < 200 && s !== v; i++)
      @(negedge core_clk);
    chk("handshake", 16'(s), 16'(v));
    if (s !== v)
      close_out();
  endtask : wait_for
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    n_errors++;
    close_out();
  end

  initial
  begin
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    foreach (tab[i])
      rc(tab[i][27:16], tab[i][15:0]);
    wait_for(ready, 1'b1);
    rc(12'h118, 16'h0004);
    chk("ind", 16'(ind), 16'h0080);
    chk("cfg", 16'(cfg), 16'h000E);
    cpu(1'b1, 12'h10F, 16'h0001);
    @(negedge core_clk);
    chk("cfg", 16'(cfg), 16'h000F);
    ev[11] = 1'b1;
    @(negedge core_clk);
    chk("cfg", 16'(cfg), 16'h002F);
    ev[11] = 1'b0;
    ev[12] = 1'b1;
    @(negedge core_clk);
    chk("cfg", 16'(cfg), 16'h000F);
    ev[12] = 1'b0;
    cpu(1'b1, 12'h120, 16'hA5C3);
    u_link_host_model.xfer(1'b0, 12'h120, 16'h0000, rd);
    chk("link", rd, 16'hA5C3);
    u_link_host_model.xfer(1'b1, 12'hDFF, 16'hFFFF, rd);
    rc(12'hDFF, 16'hFFFF);
    cpu(1'b1, 12'h116, 16'h1234);
    rc(12'h116, 16'h0000);
    rc(12'h10E, 16'h0000);
    pulse(0);
    pulse(3);
    chk("ind", 16'(ind), 16'h008A);
    rc(12'h101, 16'h000A);
    cpu(1'b1, 12'h102, 16'h0008);
    repeat (2) @(negedge core_clk);
    chk("ind", 16'(ind), 16'h0082);
    rc(12'h101, 16'h0002);
    pulse(6);
    chk("ind", 16'(ind), 16'h0092);
    pulse(7);
    chk("ind", 16'(ind), 16'h00A2);
    cpu(1'b1, 12'h119, 16'h0005);
    @(negedge core_clk);
    mode_req = 1'b1;
    wait_for(done, 1'b1);
    rc(12'h118, 16'h0005);
    chk("ind", 16'(ind), 16'h00C0);
    mode_req = 1'b0;
    wait_for(done, 1'b0);
    lts = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("ind", 16'(ind), 16'h0140);
    lts = 1'b0;
    srs = 1'b0;
    @(negedge core_clk);
    chk("ind", 16'(ind), 16'h01C0);
    close_out();
  end
endmodule : serial_link_buffer_memory_map_test
